/* src/scaler_pkg.sv */
// Constants, register map and carrier types for the video window scaler.
// Assumes one pixel clock domain and an 8-bit register port.
package scaler_pkg;

  localparam int LINE_MEM_DEPTH = 768;

  // Register offsets; 10-bit values take a low byte and a high byte above.
  localparam logic [4:0] REG_CTRL      = 5'h00;
  localparam logic [4:0] REG_FMT       = 5'h01;
  localparam logic [4:0] REG_DEST_W    = 5'h02;
  localparam logic [4:0] REG_SRC_W     = 5'h04;
  localparam logic [4:0] REG_HOFS      = 5'h06;
  localparam logic [4:0] REG_DEST_H    = 5'h08;
  localparam logic [4:0] REG_SRC_H     = 5'h0a;
  localparam logic [4:0] REG_KEY_ULO   = 5'h0c;
  localparam logic [4:0] REG_KEY_UHI   = 5'h0d;
  localparam logic [4:0] REG_KEY_VLO   = 5'h0e;
  localparam logic [4:0] REG_KEY_VHI   = 5'h0f;
  localparam logic [4:0] REG_CODING    = 5'h10;
  localparam logic [4:0] REG_VOFS      = 5'h11;
  localparam logic [4:0] REG_BYP_START = 5'h13;
  localparam logic [4:0] REG_BYP_CNT   = 5'h15;
  localparam logic [4:0] REG_LAST_RW   = 5'h16;
  localparam logic [4:0] REG_STATUS    = 5'h17;
  localparam logic [4:0] REG_LINE_LO   = 5'h18;
  localparam logic [4:0] REG_LINE_HI   = 5'h19;
  localparam logic [7:0] REG_RESET     = 8'h00;

  // Bit positions.
  localparam int CTRL_ADAPT_BIT    = 0;
  localparam int CTRL_HFILT_LSB    = 1;
  localparam int CTRL_VMODE_LO_BIT = 4;
  localparam int CTRL_VMODE_HI_BIT = 5;
  localparam int CTRL_CCODE_BIT    = 6;
  localparam int CTRL_GBYP_BIT     = 7;
  localparam int FMT_LO_BIT        = 0;
  localparam int FMT_HI_BIT        = 1;
  localparam int CODING_BIT        = 0;

  // Horizontal filter codes and vertical modes.
  localparam logic [2:0] HF_BYPASS = 3'h0;
  localparam logic [2:0] HF_2TAP   = 3'h1;
  localparam logic [2:0] HF_3TAP   = 3'h6;
  localparam logic [2:0] HF_4TAP   = 3'h3;
  localparam logic [2:0] HF_5TAP   = 3'h4;
  localparam logic [2:0] HF_9TAP   = 3'h5;
  localparam logic [1:0] VM_BYPASS = 2'h0;
  localparam logic [1:0] VM_2LINE  = 2'h1;
  localparam logic [1:0] VM_3LINE  = 2'h2;
  localparam logic [1:0] VM_WEIGHT = 2'h3;

  // Adaptive ratio thresholds, numerators over fifteenths.
  localparam logic [13:0] TH_DEN = 14'h000f;
  localparam logic [13:0] TH_H1  = 14'h000e;
  localparam logic [13:0] TH_H6  = 14'h000b;
  localparam logic [13:0] TH_H3  = 14'h0007;
  localparam logic [13:0] TH_H4  = 14'h0003;
  localparam logic [13:0] TH_V1  = 14'h000d;
  localparam logic [13:0] TH_V2  = 14'h0004;

  // Matrix coefficients in 1/64 steps.
  localparam logic signed [15:0] K_RV = 16'h0058;
  localparam logic signed [15:0] K_GV = 16'h002d;
  localparam logic signed [15:0] K_GU = 16'h0016;
  localparam logic signed [15:0] K_BU = 16'h006f;
  localparam int                 K_SHIFT = 6;

  localparam logic [7:0] LUMA_BLACK  = 8'h10;
  localparam logic [7:0] LUMA_WHITE  = 8'heb;
  localparam logic [7:0] CHROMA_FLIP = 8'h80;

  localparam logic [1:0] FMT_RGB555 = 2'h0;
  localparam logic [1:0] FMT_YUV16  = 2'h1;
  localparam logic [1:0] FMT_YUVTST = 2'h2;
  localparam logic [1:0] FMT_MONO   = 2'h3;

  // Gamma 1.4 curve sampled every 16 codes, interpolated in between.
  localparam logic [8:0] GAMMA_TAB [17] = '{
    9'h000, 9'h005, 9'h00e, 9'h019, 9'h025, 9'h032, 9'h041, 9'h051, 9'h061,
    9'h073, 9'h085, 9'h098, 9'h0ab, 9'h0c0, 9'h0d5, 9'h0ea, 9'h100};

  typedef struct packed {
    logic       keep;
    logic       mono;
    logic       odd;
    logic [9:0] idx;
  } ctl_t;

  typedef struct packed {
    logic       alpha;
    logic [1:0] fmt;
    logic [7:0] c0;
    logic [7:0] c1;
    logic [7:0] c2;
  } out_pix_t;

endpackage : scaler_pkg

/* src/video_window_scaler.sv */
// Video window scaler processing path: capture, filters, matrix, keyer,
// region control and pixel dropping. CLK is the pixel clock; the video
// inputs are assumed synchronous to it. Registers sit on a plain port.
`timescale 1ns/1ps

// Functional notes
// [R1] Luma byte and chroma byte per sample; U on even, V on odd pixels.
// [R2] Samples taken when qualifier high; line and field refs frame the scan.
// [R3] Source keeps at most 768 active pixels per line with vertical filter.
// [R4] Chroma input binary or two's complement by select bit; kept signed.
// [R5] Horizontal filters with 2, 3, 4, 5 and 9 taps.
// [R6] Adaptive bit 0 uses filter-select bits; 1 chooses from scaling ratio.
// [R7] Luma and chroma each own a two-line by 768 byte line memory.
// [R8] Without adaptive mode the two vertical-mode bits pick vertical filter.
// [R9] Adaptive mode picks filters from tightest met ratio threshold.
// [R10] Matrix: R=Y+1.375V, G=Y-0.703125V-0.34375U, B=Y+1.734375U.
// [R11] Matrix bypassed for YUV and monochrome formats.
// [R12] Gamma 1.4 tables used when table-bypass bit is 0.
// [R13] Alpha 1 when processed U and V lie within programmed thresholds.
// [R14] Lower threshold above upper disables keying.
// [R15] Keep destination of source pixels and lines; drop at output.
// [R16] Bypass region outputs all active pixels unscaled as 8-bit grey.
// [R17] Bypass region starts at its start line and spans its line count.
// [R18] Scaling starts at vertical offset line using selected format.
// [R19] Exactly source-width samples per line; short lines end at ref fall.
// [R20] Regions should not overlap; scaling region wins over bypass.
// [R21] Software sets offsets to cover processing delays.
// [R22] Output chroma coding follows coding bit; unity gain for YUV.
// [R23] Output luma limited to studio range, black at 16.
// [R24] Chroma interpolated to 4:4:4 after vertical processing.
module video_window_scaler
  import scaler_pkg::*;
(
  input  wire logic       CLK,
  input  wire logic       RST_N,
  input  wire logic       CLOCK_QUALIFIER,
  input  wire logic       LINE_ACTIVE_REF,
  input  wire logic       VERTICAL_SYNC_INPUT,
  input  wire logic [7:0] LUMA_IN_BUS,
  input  wire logic [7:0] CHROMA_IN_BUS,
  input  wire logic [4:0] REG_ADDR,
  input  wire logic [7:0] REG_WDATA,
  input  wire logic       REG_WR,
  input  wire logic       REG_RD,
  output logic      [7:0] REG_RDATA,
  output logic            PIX_OUT_VALID,
  output out_pix_t        PIX_OUT
);

  logic [7:0] regs_reg [0:22];
  logic [9:0] dest_w, src_w, hofs, dest_h, src_h, vofs, byp_start, byp_cnt;
  logic       adapt;
  logic [2:0] hsel, hsel_auto;
  logic [1:0] vmode, vmode_auto;

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      for (int i = 0; i <= 22; i++) regs_reg[i] <= REG_RESET;
    end else if (REG_WR && REG_ADDR <= REG_LAST_RW) begin
      regs_reg[REG_ADDR] <= REG_WDATA;
    end
  end

  function automatic logic [9:0] par10(input logic [4:0] a);
    par10 = {regs_reg[a + 5'h01][1:0], regs_reg[a]};
  endfunction : par10

  function automatic logic ratio_le(input logic [9:0] d, input logic [9:0] s,
                                    input logic [13:0] k);
    ratio_le = (14'(d) * TH_DEN) <= (14'(s) * k);
  endfunction : ratio_le

  assign dest_w    = par10(REG_DEST_W);
  assign src_w     = par10(REG_SRC_W);
  assign hofs      = par10(REG_HOFS);
  assign dest_h    = par10(REG_DEST_H);
  assign src_h     = par10(REG_SRC_H);
  assign vofs      = par10(REG_VOFS);
  assign byp_start = par10(REG_BYP_START);
  assign byp_cnt   = par10(REG_BYP_CNT);
  assign adapt     = regs_reg[REG_CTRL][CTRL_ADAPT_BIT];

  always_comb begin
    if (ratio_le(dest_w, src_w, TH_H4)) hsel_auto = HF_5TAP; // [R9]
    else if (ratio_le(dest_w, src_w, TH_H3)) hsel_auto = HF_4TAP;
    else if (ratio_le(dest_w, src_w, TH_H6)) hsel_auto = HF_3TAP;
    else if (ratio_le(dest_w, src_w, TH_H1)) hsel_auto = HF_2TAP;
    else hsel_auto = HF_BYPASS;
    if (ratio_le(dest_h, src_h, TH_V2)) vmode_auto = VM_3LINE; // [R9]
    else if (ratio_le(dest_h, src_h, TH_V1)) vmode_auto = VM_2LINE;
    else vmode_auto = VM_BYPASS;
  end

  assign hsel  = adapt ? hsel_auto                                   // [R6]
               : regs_reg[REG_CTRL][CTRL_HFILT_LSB +: 3];
  assign vmode = adapt ? vmode_auto                                  // [R8]
               : {regs_reg[REG_CTRL][CTRL_VMODE_HI_BIT],
                  regs_reg[REG_CTRL][CTRL_VMODE_LO_BIT]};

  // Scan position and region control.
  logic        line_active_ref_q, vs_q, sample, line_active_ref_rise, line_active_ref_fall, vs_rise;
  logic [9:0]  line_cnt, pix_cnt, hacc, vacc;
  logic [10:0] hsum, vsum;
  logic        in_scale, in_bypass, line_keep, h_win, keep_now;

  assign sample    = CLOCK_QUALIFIER & LINE_ACTIVE_REF;              // [R2]
  assign line_active_ref_rise = LINE_ACTIVE_REF & ~line_active_ref_q;
  assign line_active_ref_fall = line_active_ref_q & ~LINE_ACTIVE_REF;
  assign vs_rise   = VERTICAL_SYNC_INPUT & ~vs_q;

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      line_active_ref_q <= 1'b0;
      vs_q   <= 1'b0;
    end else begin
      line_active_ref_q <= LINE_ACTIVE_REF;
      vs_q   <= VERTICAL_SYNC_INPUT;
    end
  end

  always_ff @(posedge CLK) begin
    if (!RST_N) line_cnt <= 10'h000;
    else if (vs_rise) line_cnt <= 10'h000;
    else if (line_active_ref_fall && line_cnt != 10'h3ff) line_cnt <= line_cnt + 10'h001;
  end

  assign in_scale  = ({1'b0, line_cnt} >= {1'b0, vofs}) &&           // [R18]
                     ({1'b0, line_cnt} < ({1'b0, vofs} + {1'b0, src_h}));
  assign in_bypass = !in_scale &&                                    // [R20]
                     ({1'b0, line_cnt} >= {1'b0, byp_start}) &&      // [R17]
                     ({1'b0, line_cnt} <
                      ({1'b0, byp_start} + {1'b0, byp_cnt}));

  // Line selection: accumulate destination height, keep on overflow.
  assign vsum = {1'b0, vacc} + {1'b0, dest_h};
  always_ff @(posedge CLK) begin
    if (!RST_N || vs_rise) begin
      vacc      <= 10'h000;
      line_keep <= 1'b0;
    end else if (line_active_ref_rise) begin
      if (!in_scale) begin
        line_keep <= 1'b0;
      end else if (vsum >= {1'b0, src_h}) begin                      // [R15]
        line_keep <= 1'b1;
        vacc      <= 10'(vsum - {1'b0, src_h});
      end else begin
        line_keep <= 1'b0;
        vacc      <= vsum[9:0];
      end
    end
  end

  // Pixel selection inside the source-width window only.
  assign h_win = ({1'b0, pix_cnt} >= {1'b0, hofs}) &&                // [R19]
                 ({1'b0, pix_cnt} < ({1'b0, hofs} + {1'b0, src_w}));
  assign hsum  = {1'b0, hacc} + {1'b0, dest_w};

  always_ff @(posedge CLK) begin
    if (!RST_N || line_active_ref_fall) begin                                   // [R19]
      pix_cnt <= 10'h000;
      hacc    <= 10'h000;
    end else if (sample) begin
      if (pix_cnt != 10'h3ff) pix_cnt <= pix_cnt + 10'h001;
      if (h_win) begin
        hacc <= (hsum >= {1'b0, src_w}) ? 10'(hsum - {1'b0, src_w})
                                        : hsum[9:0];
      end
    end
  end

  // The first sample of a line shares the edge with the line decision.
  assign keep_now = in_bypass ? 1'b1                                 // [R16]
                  : ((line_active_ref_rise ? in_scale && vsum >= {1'b0, src_h}
                                : line_keep)
                     && h_win && hsum >= {1'b0, src_w});             // [R15]

  // Stage A: capture and chroma conversion to two's complement.
  logic       va;
  logic [7:0] ya, ca;
  ctl_t       ctl_a;
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      va    <= 1'b0;
      ya    <= 8'h00;
      ca    <= 8'h00;
      ctl_a <= '0;
    end else begin
      va <= sample;
      if (sample) begin
        ya    <= LUMA_IN_BUS;                                        // [R1]
        ca    <= regs_reg[REG_CTRL][CTRL_CCODE_BIT] ? CHROMA_IN_BUS  // [R4]
                 : CHROMA_IN_BUS ^ CHROMA_FLIP;
        ctl_a <= '{keep: keep_now, mono: in_bypass,
                   odd: pix_cnt[0], idx: pix_cnt};                   // [R1]
      end
    end
  end

  // Stage B: horizontal decimation filters.
  logic [7:0][7:0] y_sh, c_sh;
  logic [8:0][7:0] ytap;
  logic            vb;
  logic [7:0]      yb, cb;
  ctl_t            ctl_b;
  assign ytap = {y_sh, ya};

  function automatic logic [7:0] hfilt(input logic [2:0] sel,
                                       input logic [8:0][7:0] t);
    logic [11:0] s;
    s = 12'(t[0]);
    case (sel)
      HF_2TAP: s = (12'(t[0]) + 12'(t[1])) >> 1;
      HF_3TAP: s = (12'(t[0]) + (12'(t[1]) << 1) + 12'(t[2])) >> 2;
      HF_4TAP: s = (12'(t[0]) + 12'(t[1]) * 12'h003 + 12'(t[2]) * 12'h003
                    + 12'(t[3])) >> 3;
      HF_5TAP: s = (12'(t[0]) + (12'(t[1]) << 2) + 12'(t[2]) * 12'h006
                    + (12'(t[3]) << 2) + 12'(t[4])) >> 4;
      HF_9TAP: s = (12'(t[0]) + 12'(t[8]) + ((12'(t[1]) + 12'(t[2])
                    + 12'(t[3]) + 12'(t[4]) + 12'(t[5]) + 12'(t[6])
                    + 12'(t[7])) << 1)) >> 4;
      default: s = 12'(t[0]);
    endcase
    hfilt = s[7:0];
  endfunction : hfilt

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      y_sh  <= '0;
      c_sh  <= '0;
      vb    <= 1'b0;
      yb    <= 8'h00;
      cb    <= 8'h00;
      ctl_b <= '0;
    end else begin
      vb <= va;
      if (va) begin
        y_sh  <= {y_sh[6:0], ya};
        c_sh  <= {c_sh[6:0], ca};
        yb    <= hfilt(hsel, ytap);                                  // [R5]
        // Chroma pairs same-component samples two positions apart.
        cb    <= (hsel == HF_BYPASS) ? ca
                 : 8'(({ca[7], ca} + {c_sh[1][7], c_sh[1]}) >>> 1);
        ctl_b <= ctl_a;
      end
    end
  end

  // Stage C: vertical filter over two stored lines, chroma interpolation.
  logic [7:0] ymem [2][LINE_MEM_DEPTH];
  logic [7:0] cmem [2][LINE_MEM_DEPTH];
  logic       wbank, mem_ok;
  logic [7:0] y1, y2, c1, c2, yv, cv, u_hold, v_hold, yc, uc, vc;
  logic       vcv;
  ctl_t       ctl_c;

  function automatic logic [7:0] vfilt(input logic [1:0] m,
      input logic [7:0] a, input logic [7:0] b, input logic [7:0] c,
      input logic sgn);
    logic signed [10:0] ea, eb, ec, s;
    ea = sgn ? {{3{a[7]}}, a} : {3'b000, a};
    eb = sgn ? {{3{b[7]}}, b} : {3'b000, b};
    ec = sgn ? {{3{c[7]}}, c} : {3'b000, c};
    s  = ea;
    unique case (m)
      VM_BYPASS: s = ea;
      VM_2LINE:  s = (ea + eb) >>> 1;
      VM_3LINE:  s = (ea + (eb <<< 1) + ec) >>> 2;
      VM_WEIGHT: s = (ea + eb + (eb <<< 1)) >>> 2;
    endcase
    vfilt = s[7:0];
  endfunction : vfilt

  // Pixels past the memory depth read as zero rather than wrap.
  assign mem_ok = ctl_b.idx < 10'(LINE_MEM_DEPTH);                   // [R3]
  assign y1 = mem_ok ? ymem[~wbank][ctl_b.idx] : 8'h00;
  assign y2 = mem_ok ? ymem[wbank][ctl_b.idx]  : 8'h00;
  assign c1 = mem_ok ? cmem[~wbank][ctl_b.idx] : 8'h00;
  assign c2 = mem_ok ? cmem[wbank][ctl_b.idx]  : 8'h00;
  assign yv = vfilt(vmode, yb, y1, y2, 1'b0);                        // [R8]
  assign cv = vfilt(vmode, cb, c1, c2, 1'b1);

  // Bank swap at line start relies on blanking longer than the pipe.
  always_ff @(posedge CLK) begin
    if (!RST_N) wbank <= 1'b0;
    else if (line_active_ref_rise) wbank <= ~wbank;
  end

  always_ff @(posedge CLK) begin
    if (vb && mem_ok) begin
      ymem[wbank][ctl_b.idx] <= yb;                                  // [R7]
      cmem[wbank][ctl_b.idx] <= cb;                                  // [R7]
    end
  end

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      u_hold <= 8'h00;
      v_hold <= 8'h00;
      vcv    <= 1'b0;
      yc     <= 8'h00;
      uc     <= 8'h00;
      vc     <= 8'h00;
      ctl_c  <= '0;
    end else begin
      vcv <= vb;
      if (vb) begin
        if (ctl_b.odd) v_hold <= cv;
        else u_hold <= cv;
        yc    <= yv;
        uc    <= ctl_b.odd ? u_hold : cv;                            // [R24]
        vc    <= ctl_b.odd ? cv : v_hold;                            // [R24]
        ctl_c <= ctl_b;
      end
    end
  end

  // Stage D: matrix, gamma, keyer, formatting and output dropping.
  logic signed [15:0] ys, us, vs, r16, g16, b16;
  logic [7:0]         rr, gg, bb, ylim, uo, vo, ub, vbin;
  logic [1:0]         fmt;
  logic               alpha;
  out_pix_t           pix;

  function automatic logic [7:0] clamp8(input logic signed [15:0] x);
    if (x < 16'sh0000) clamp8 = 8'h00;
    else if (x > 16'sh00ff) clamp8 = 8'hff;
    else clamp8 = x[7:0];
  endfunction : clamp8

  function automatic logic [7:0] gamma(input logic [7:0] x, input logic byp);
    logic [8:0]  lo, hi;
    logic [12:0] d;
    lo = GAMMA_TAB[x[7:4]];
    hi = GAMMA_TAB[{1'b0, x[7:4]} + 5'h01];
    d  = 13'(hi - lo) * {9'h000, x[3:0]};
    gamma = byp ? x : 8'(lo + 9'(d >> 4));
  endfunction : gamma

  assign ys  = {8'h00, yc};
  assign us  = {{8{uc[7]}}, uc};
  assign vs  = {{8{vc[7]}}, vc};
  assign r16 = ys + ((vs * K_RV) >>> K_SHIFT);                       // [R10]
  assign g16 = ys - ((vs * K_GV) >>> K_SHIFT)
                  - ((us * K_GU) >>> K_SHIFT);                       // [R10]
  assign b16 = ys + ((us * K_BU) >>> K_SHIFT);                       // [R10]
  assign rr  = gamma(clamp8(r16), regs_reg[REG_CTRL][CTRL_GBYP_BIT]); // [R12]
  assign gg  = gamma(clamp8(g16), regs_reg[REG_CTRL][CTRL_GBYP_BIT]); // [R12]
  assign bb  = gamma(clamp8(b16), regs_reg[REG_CTRL][CTRL_GBYP_BIT]); // [R12]

  // Keying compares straight-binary chroma; an empty range never matches.
  assign ub    = uc ^ CHROMA_FLIP;
  assign vbin  = vc ^ CHROMA_FLIP;
  assign alpha = (ub >= regs_reg[REG_KEY_ULO]) &&                    // [R13]
                 (ub <= regs_reg[REG_KEY_UHI]) &&                    // [R14]
                 (vbin >= regs_reg[REG_KEY_VLO]) &&
                 (vbin <= regs_reg[REG_KEY_VHI]);

  assign ylim = (yc < LUMA_BLACK) ? LUMA_BLACK                       // [R23]
              : (yc > LUMA_WHITE) ? LUMA_WHITE : yc;
  assign uo   = regs_reg[REG_CODING][CODING_BIT] ? uc : ub;          // [R22]
  assign vo   = regs_reg[REG_CODING][CODING_BIT] ? vc : vbin;        // [R22]
  assign fmt  = ctl_c.mono ? FMT_MONO                                // [R16]
              : {regs_reg[REG_FMT][FMT_HI_BIT],
                 regs_reg[REG_FMT][FMT_LO_BIT]};                     // [R18]

  always_comb begin
    pix = '{alpha: 1'b0, fmt: fmt, c0: ylim, c1: 8'h00, c2: 8'h00};
    unique case (fmt)
      FMT_RGB555: begin
        pix.alpha = alpha;
        pix.c0    = {rr[7:3], 3'b000};
        pix.c1    = {gg[7:3], 3'b000};
        pix.c2    = {bb[7:3], 3'b000};
      end
      FMT_YUV16, FMT_YUVTST: begin                                   // [R11]
        pix.c1 = uo;
        pix.c2 = vo;
      end
      FMT_MONO: pix.c0 = ylim;                                       // [R11]
    endcase
  end

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      PIX_OUT_VALID <= 1'b0;
      PIX_OUT       <= '0;
    end else begin
      PIX_OUT_VALID <= vcv && ctl_c.keep;                            // [R15]
      if (vcv) PIX_OUT <= pix;
    end
  end

  // Register reads: data in the cycle after the strobe, zero otherwise.
  always_ff @(posedge CLK) begin
    if (!RST_N || !REG_RD) REG_RDATA <= 8'h00;
    else if (REG_ADDR <= REG_LAST_RW) REG_RDATA <= regs_reg[REG_ADDR];
    else if (REG_ADDR == REG_STATUS)
      REG_RDATA <= {5'h00, wbank, in_scale, in_bypass};
    else if (REG_ADDR == REG_LINE_LO) REG_RDATA <= line_cnt[7:0];
    else if (REG_ADDR == REG_LINE_HI) REG_RDATA <= {6'h00, line_cnt[9:8]};
    else REG_RDATA <= 8'h00;
  end

endmodule : video_window_scaler

/* dv/scaler_checker.sv */
// Concurrent checks on the scaler output and register read port.
// Assumes one pixel clock and a synchronous active-low reset.
`timescale 1ns/1ps
module scaler_checker
  import scaler_pkg::*;
(
  input wire logic       CLK,
  input wire logic       RST_N,
  input wire logic       CLOCK_QUALIFIER,
  input wire logic       LINE_ACTIVE_REF,
  input wire logic       REG_RD,
  input wire logic [7:0] REG_RDATA,
  input wire logic       PIX_OUT_VALID,
  input wire out_pix_t   PIX_OUT
);
  default clocking @(posedge CLK); endclocking
  default disable iff (!RST_N);

  // A pixel leaves the pipeline four edges after its sample was taken.
  sequence taken_4ago;
    $past(CLOCK_QUALIFIER && LINE_ACTIVE_REF, 4);
  endsequence
  sequence line_idle;
    !LINE_ACTIVE_REF [*4];
  endsequence

  chk_valid_latency: assert property (
    PIX_OUT_VALID |-> taken_4ago) else $error("valid without sample");
  chk_out_hold: assert property (
    $changed(PIX_OUT) |-> taken_4ago) else $error("output moved alone");
  chk_idle_line: assert property (
    line_idle |=> !PIX_OUT_VALID) else $error("pixel outside line");
  chk_rgb_trunc: assert property (
    PIX_OUT_VALID && PIX_OUT.fmt == FMT_RGB555 |-> PIX_OUT.c0[2:0] == 3'h0
    && PIX_OUT.c1[2:0] == 3'h0 && PIX_OUT.c2[2:0] == 3'h0)
    else $error("rgb low bits set");
  chk_mono_chroma: assert property (
    PIX_OUT_VALID && PIX_OUT.fmt == FMT_MONO |-> PIX_OUT.c1 == 8'h00
    && PIX_OUT.c2 == 8'h00) else $error("grey carries chroma");
  chk_luma_range: assert property (
    PIX_OUT_VALID && PIX_OUT.fmt != FMT_RGB555 |-> PIX_OUT.c0 >= LUMA_BLACK
    && PIX_OUT.c0 <= LUMA_WHITE) else $error("luma out of range");
  chk_alpha_rgb_only: assert property (
    PIX_OUT_VALID && PIX_OUT.fmt != FMT_RGB555 |-> !PIX_OUT.alpha)
    else $error("alpha outside rgb");
  chk_read_slot: assert property (
    REG_RDATA != 8'h00 |-> $past(REG_RD)) else $error("stray read data");
endmodule : scaler_checker

bind video_window_scaler scaler_checker scaler_checker_i (
  .CLK(CLK), .RST_N(RST_N), .CLOCK_QUALIFIER(CLOCK_QUALIFIER),
  .LINE_ACTIVE_REF(LINE_ACTIVE_REF), .REG_RD(REG_RD),
  .REG_RDATA(REG_RDATA), .PIX_OUT_VALID(PIX_OUT_VALID), .PIX_OUT(PIX_OUT));

/* dv/video_source.sv */
// Model of the decoder that feeds 4:2:2 samples to the scaler.
// Assumes the bench calls its tasks from one process at a time.
`timescale 1ns/1ps
module video_source (
  input  wire logic       clk,
  output logic            qual,
  output logic            line_ref,
  output logic            vsync,
  output logic      [7:0] luma,
  output logic      [7:0] chroma
);
  localparam int MAX_ACTIVE = 768;

  initial begin
    qual = 1'b0;
    line_ref = 1'b0;
    vsync = 1'b0;
    luma = 8'h00;
    chroma = 8'h00;
  end

  task automatic field_start();
    @(posedge clk);
    vsync <= 1'b1;
    @(posedge clk);
    vsync <= 1'b0;
    repeat (3) @(posedge clk);
  endtask : field_start

  task automatic send_line(input int n, input logic [7:0] y, u, v);
    int cnt;
    cnt = (n > MAX_ACTIVE) ? MAX_ACTIVE : n;
    for (int i = 0; i < cnt; i++) begin
      @(posedge clk);
      line_ref <= 1'b1;
      qual <= 1'b1;
      luma <= y;
      chroma <= i[0] ? v : u;
    end
    @(posedge clk);
    line_ref <= 1'b0;
    qual <= 1'b0;
    // Released buses show no stale value, so a late sample cannot pass.
    luma <= ~y;
    chroma <= ~chroma;
    repeat (8) @(posedge clk);
  endtask : send_line
endmodule : video_source

/* dv/test_video_window_scaler.sv */
// Self-checking bench for the video window scaler.
// Assumes the checker is bound from its own file.
`timescale 1ns/1ps
`define CHECK(name, exp, got) begin checks++; if ((got) !== (exp)) begin \
  miscompares++; $display("unexpected %s: expected %h, seen %h", name, \
  exp, got); end end
module test_video_window_scaler
  import scaler_pkg::*;
;
  logic       clk = 1'b0;
  logic       rst_n = 1'b0;
  logic       qual, line_ref, vsync, reg_wr = 1'b0, reg_rd = 1'b0;
  logic [7:0] luma, chroma, reg_wdata = 8'h00, reg_rdata;
  logic [4:0] reg_addr = 5'h00;
  logic       pix_valid;
  out_pix_t   pix, last_pix;
  int         n_valid = 0, cycles = 0, checks = 0, miscompares = 0;

  always #4 clk = ~clk;

  video_window_scaler video_window_scaler_i (.CLK(clk), .RST_N(rst_n),
    .CLOCK_QUALIFIER(qual), .LINE_ACTIVE_REF(line_ref),
    .VERTICAL_SYNC_INPUT(vsync), .LUMA_IN_BUS(luma),
    .CHROMA_IN_BUS(chroma), .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata),
    .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_RDATA(reg_rdata),
    .PIX_OUT_VALID(pix_valid), .PIX_OUT(pix));
  video_source video_source_i (.clk(clk), .qual(qual), .line_ref(line_ref),
    .vsync(vsync), .luma(luma), .chroma(chroma));

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (pix_valid) begin
      n_valid <= n_valid + 1;
      last_pix <= pix;
    end
    if (cycles == 20000) begin
      miscompares++;
      final_report();
    end
  end

  task automatic final_report();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : final_report

  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [4:0] a, output logic [7:0] d);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(posedge clk);
    d = reg_rdata;
  endtask : rd

  task automatic run_line(input int n, input logic [7:0] y, u, v,
                          output int got);
    int base;
    base = n_valid;
    video_source_i.send_line(n, y, u, v);
    got = n_valid - base;
  endtask : run_line

  task automatic t_regs();
    logic [7:0] d;
    rd(REG_CTRL, d);
    `CHECK("ctrl reset", 8'h00, d)
    wr(REG_CTRL, 8'ha5);
    rd(REG_CTRL, d);
    `CHECK("ctrl", 8'ha5, d)
    wr(5'h1b, 8'h5a);
    rd(5'h1b, d);
    `CHECK("unmapped", 8'h00, d)
    wr(REG_CTRL, 8'h00);
  endtask : t_regs

  task automatic t_bypass();
    int got;
    wr(REG_BYP_START, 8'h00);
    wr(REG_BYP_CNT, 8'h02);
    wr(REG_FMT, {6'h00, FMT_RGB555});
    video_source_i.field_start();
    run_line(6, 8'h05, 8'h80, 8'h80, got);
    `CHECK("bypass count", 6, got)
    `CHECK("grey fmt", FMT_MONO, last_pix.fmt)
    `CHECK("black clamp", LUMA_BLACK, last_pix.c0)
    run_line(6, 8'h05, 8'h80, 8'h80, got);
    `CHECK("second bypass", 6, got)
    run_line(6, 8'h05, 8'h80, 8'h80, got);
    `CHECK("after bypass", 0, got)
  endtask : t_bypass

  task automatic t_scale();
    int got;
    logic [7:0] ui, vi, uo, vo;
    wr(REG_BYP_CNT, 8'hff);
    wr(REG_DEST_W, 8'h04);
    wr(REG_SRC_W, 8'h08);
    wr(REG_DEST_H, 8'hff);
    wr(REG_SRC_H, 8'hff);
    wr(REG_VOFS, 8'h00);
    wr(REG_FMT, {6'h00, FMT_YUV16});
    video_source_i.field_start();
    run_line(10, 8'h60, 8'h90, 8'h70, got);
    `CHECK("kept pixels", 4, got)
    `CHECK("scaling wins", FMT_YUV16, last_pix.fmt)
    run_line(4, 8'h60, 8'h90, 8'h70, got);
    `CHECK("short line", 2, got)
    for (int k = 0; k < 4; k++) begin
      wr(REG_CTRL, {1'b0, k[0], 6'h00});
      wr(REG_CODING, {7'h00, k[1]});
      ui = k[0] ? 8'h10 : 8'h90;
      vi = k[0] ? 8'hf0 : 8'h70;
      uo = k[1] ? 8'h10 : 8'h90;
      vo = k[1] ? 8'hf0 : 8'h70;
      run_line(10, 8'h60, ui, vi, got);
      `CHECK("u out", uo, last_pix.c1)
      `CHECK("v out", vo, last_pix.c2)
    end
    `CHECK("luma unity", 8'h60, last_pix.c0)
  endtask : t_scale

  task automatic t_key();
    int got;
    logic [7:0] g;
    wr(REG_FMT, {6'h00, FMT_RGB555});
    wr(REG_CODING, 8'h00);
    wr(REG_KEY_ULO, 8'h70);
    wr(REG_KEY_UHI, 8'h90);
    wr(REG_KEY_VLO, 8'h70);
    wr(REG_KEY_VHI, 8'h90);
    for (int k = 0; k < 2; k++) begin
      wr(REG_CTRL, {~k[0], 7'h00});
      run_line(10, 8'h80, 8'h80, 8'h80, got);
      g = k[0] ? GAMMA_TAB[8][7:0] : 8'h80;
      `CHECK("red", g & 8'hf8, last_pix.c0)
      `CHECK("green", g & 8'hf8, last_pix.c1)
      `CHECK("blue", g & 8'hf8, last_pix.c2)
      `CHECK("alpha in", 1'b1, last_pix.alpha)
    end
    wr(REG_KEY_ULO, 8'ha0);
    run_line(10, 8'h80, 8'h80, 8'h80, got);
    `CHECK("alpha off", 1'b0, last_pix.alpha)
  endtask : t_key

  initial begin
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    t_regs();
    t_bypass();
    t_scale();
    t_key();
    final_report();
  end
endmodule : test_video_window_scaler
